//--- core/lpp_cfg.svh
// register map, field layout and timing constants of the sleep-mode polling bank
// Function
// - frame holds address, write flag, 24 data bits
// - slow ground channels polled every fourth round
// - other ground channels polled every normal round
// - ground slow-poll register at 0x19, bits 13..0
// - debounce channels keep current 1.2 ms longer
// - non-debounce channels use voltage difference sampling
// - programmable debounce register at 0x1a, bits 7..0
// - ground debounce register at 0x1b, bits 13..0
// - only the sleep command enters sleep mode
// - sleep command write-only, starts polling
// - leaving sleep keeps every register setting
// - first frame after wake: flags high, inputs
// - every reply carries fault and interrupt flags
// - switch status read clears interrupt flag
`ifndef LPP_CFG_SVH
`define LPP_CFG_SVH

`define LPP_ADDR_MSB 31
`define LPP_ADDR_LSB 25
`define LPP_RW_BIT 24
`define LPP_FAULT_BIT 23
`define LPP_INT_BIT 22
`define LPP_FRAME_BITS 6'h20
`define LPP_GND_CH 14
`define LPP_PRG_CH 8

`define LPP_ADDR_SLOW_GND 7'h19
`define LPP_ADDR_DEB_PRG 7'h1a
`define LPP_ADDR_DEB_GND 7'h1b
`define LPP_ADDR_SLEEP 7'h1c
`define LPP_ADDR_SW_STATUS 7'h1f

`define LPP_RST_SLOW_GND 14'h0000
`define LPP_RST_DEB_PRG 8'h00
`define LPP_RST_DEB_GND 14'h0000
`define LPP_RST_REPLY 32'h00c00000
`define LPP_FLAGS_WAKE 2'h3
`define LPP_PIN_IDLE 3'h2

`define LPP_SLOW_LAST 2'h3
`define LPP_CLK_HZ 40000000
`define LPP_DEB_EXT_US 1200
`define LPP_DEB_EXT_CYC (((`LPP_DEB_EXT_US) * (`LPP_CLK_HZ / 1000000)))
`define LPP_POLL_BASE_CYC 64

`endif

//--- core/lpp_pkg.sv
// types shared by the sleep-mode polling bank
package lpp_pkg;
    typedef enum logic [0:0] {st_normal, st_sleep} lpp_mode_t;
    typedef logic [6:0] lpp_addr_t;
    typedef logic [31:0] lpp_frame_t;
    typedef logic [21:0] lpp_data_t;
    typedef logic [13:0] lpp_gnd_t;
    typedef logic [7:0] lpp_prg_t;
endpackage

//--- core/lpp_poll_sched.sv
// low-power polling scheduler: round timing, slow rounds, debounce extension
`include "lpp_cfg.svh"
module lpp_poll_sched #(
    parameter int unsigned BASE_CYC = `LPP_POLL_BASE_CYC,
    parameter int unsigned EXT_CYC = `LPP_DEB_EXT_CYC
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // configuration
    input wire logic sleep_mode_i,
    input wire logic poll_tick_i,
    input wire lpp_pkg::lpp_gnd_t slow_gnd_i,
    input wire lpp_pkg::lpp_gnd_t deb_gnd_i,
    input wire lpp_pkg::lpp_prg_t deb_prg_i,
    // polling drive
    output lpp_pkg::lpp_gnd_t gnd_current_o,
    output lpp_pkg::lpp_prg_t prg_current_o,
    output lpp_pkg::lpp_gnd_t gnd_measure_o,
    output lpp_pkg::lpp_prg_t prg_measure_o
);
    import lpp_pkg::*;

    // timer is 17 bits: base plus extension must stay below 2^17 cycles
    localparam logic [16:0] BASE_END = 17'(BASE_CYC - 1);
    localparam logic [16:0] EXT_END = 17'(BASE_CYC + EXT_CYC - 1);

    logic [1:0] round_cnt, next_round_cnt;
    logic slow_round, next_slow_round;
    logic active, next_active;
    logic [16:0] timer, next_timer;
    lpp_data_t member, deb_all, cur_now, meas_now;
    logic start;

    assign deb_all = {deb_prg_i, deb_gnd_i};
    assign member = {{`LPP_PRG_CH{1'b1}}, ~slow_gnd_i | {`LPP_GND_CH{slow_round}}};
    assign start = !active && sleep_mode_i && poll_tick_i;

    // ----------------------------------------------------------------
    // round sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        next_round_cnt = round_cnt;
        next_slow_round = slow_round;
        next_active = active;
        next_timer = timer;
        if (start)
        begin
            next_active = 1'b1;
            next_timer = 17'h0;
            next_slow_round = (round_cnt == 2'h0);
            next_round_cnt = (round_cnt == `LPP_SLOW_LAST) ? 2'h0 : round_cnt + 2'h1;
        end
        else if (active && (!sleep_mode_i || timer == EXT_END))
        begin
            next_active = 1'b0;
        end
        else if (active)
        begin
            next_timer = timer + 17'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 22; gi++)
        begin : g_ch
            // debounce channels hold current past the base window
            assign cur_now[gi] = active && member[gi] && ((timer <= BASE_END) || deb_all[gi]);
            assign meas_now[gi] = active && member[gi] &&
                (deb_all[gi] ? (timer == EXT_END) : (timer == BASE_END));
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            round_cnt <= 2'h0;
            slow_round <= 1'b0;
            active <= 1'b0;
            timer <= 17'h0;
            gnd_current_o <= '0;
            prg_current_o <= '0;
            gnd_measure_o <= '0;
            prg_measure_o <= '0;
        end
        else if (clk_en_i)
        begin
            round_cnt <= next_round_cnt;
            slow_round <= next_slow_round;
            active <= next_active;
            timer <= next_timer;
            gnd_current_o <= cur_now[13:0];
            prg_current_o <= cur_now[21:14];
            gnd_measure_o <= meas_now[13:0];
            prg_measure_o <= meas_now[21:14];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i iff clk_en_i);
    endclocking
    default disable iff (!rst_b_i);

    a_slow_skipped: assert property (active && !slow_round |-> (cur_now[13:0] & slow_gnd_i) == 14'h0)
        else $error("slow channel polled in a normal round");
    a_slow_every_fourth: assert property (start && round_cnt != 2'h0 |=> !slow_round)
        else $error("slow round taken off the fourth tick");
    a_normal_all_polled: assert property (active && timer == 17'h0 |-> &(cur_now[13:0] | slow_gnd_i))
        else $error("normal channel missed in a round");
    a_deb_hold_only: assert property (active && timer > BASE_END |-> (cur_now & ~deb_all) == 22'h0)
        else $error("non-debounce channel driven past base window");
    a_diff_sample: assert property (active && timer == BASE_END |-> meas_now == (member & ~deb_all))
        else $error("voltage difference sample at wrong time");
    c_debounce_round: cover property (active && timer == EXT_END && (deb_all & member) != 22'h0);
endmodule

//--- core/lpp_sleep_cfg.sv
// sleep-mode polling configuration bank behind the serial command port
`include "lpp_cfg.svh"
module lpp_sleep_cfg #(
    parameter int unsigned POLL_BASE_CYC = `LPP_POLL_BASE_CYC,
    parameter int unsigned DEB_EXT_CYC = `LPP_DEB_EXT_CYC
) (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // serial command pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_b_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // switch front end
    input wire lpp_pkg::lpp_gnd_t ground_switch_input_state_i,
    input wire lpp_pkg::lpp_prg_t programmable_switch_input_state_i,
    input wire logic fault_pending_i,
    input wire logic int_event_i,
    input wire logic wake_i,
    input wire logic poll_tick_i,
    // low-power polling
    output logic sleep_mode_o,
    output lpp_pkg::lpp_gnd_t ground_switch_input_current_o,
    output lpp_pkg::lpp_prg_t programmable_switch_input_current_o,
    output lpp_pkg::lpp_gnd_t ground_switch_input_measure_o,
    output lpp_pkg::lpp_prg_t programmable_switch_input_measure_o
);
    import lpp_pkg::*;

    function automatic logic addr_is(input lpp_frame_t frame, input lpp_addr_t addr);
        return frame[`LPP_ADDR_MSB:`LPP_ADDR_LSB] == addr;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // three stages on every pin limit the serial clock to about a tenth of clk_sys
    logic [2:0] pin_raw, sync1, sync2, sync3, pin_stable, next_pin_stable;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;

    assign pin_raw = {spi_sclk_i, spi_cs_b_i, spi_mosi_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_pin
            assign next_pin_stable[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : pin_stable[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sync1 <= `LPP_PIN_IDLE;
            sync2 <= `LPP_PIN_IDLE;
            sync3 <= `LPP_PIN_IDLE;
            pin_stable <= `LPP_PIN_IDLE;
        end
        else if (clk_en_i)
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_stable <= next_pin_stable;
        end
    end

    assign sclk_rise = next_pin_stable[2] && !pin_stable[2];
    assign sclk_fall = !next_pin_stable[2] && pin_stable[2];
    assign cs_rise = next_pin_stable[1] && !pin_stable[1];
    assign cs_fall = !next_pin_stable[1] && pin_stable[1];

    // ----------------------------------------------------------------
    // frame shifter
    // ----------------------------------------------------------------
    lpp_frame_t rx_shift, next_rx_shift, tx_shift, next_tx_shift, reply_q, next_reply_q;
    lpp_frame_t wake_word;
    logic [5:0] bit_cnt, next_bit_cnt;
    logic in_frame, next_in_frame, frame_done;
    logic wake_pending, next_wake_pending;

    assign wake_word = {8'h00, `LPP_FLAGS_WAKE, programmable_switch_input_state_i,
        ground_switch_input_state_i};

    always_comb
    begin
        next_rx_shift = rx_shift;
        next_tx_shift = tx_shift;
        next_bit_cnt = bit_cnt;
        next_in_frame = in_frame;
        frame_done = 1'b0;
        if (cs_fall)
        begin
            next_in_frame = 1'b1;
            next_bit_cnt = 6'h0;
            next_tx_shift = wake_pending ? wake_word : reply_q;
        end
        else if (in_frame)
        begin
            if (cs_rise)
            begin
                // a frame of fewer than 32 bits is dropped without effect; clocks past bit 32 are ignored
                next_in_frame = 1'b0;
                frame_done = (bit_cnt == `LPP_FRAME_BITS);
            end
            else if (sclk_rise && bit_cnt != `LPP_FRAME_BITS)
            begin
                next_rx_shift = {rx_shift[30:0], next_pin_stable[0]};
                next_bit_cnt = bit_cnt + 6'h1;
            end
            else if (sclk_fall)
            begin
                next_tx_shift = {tx_shift[30:0], 1'b0};
            end
        end
    end

    assign spi_miso_o = tx_shift[31];
    assign spi_miso_oe_o = in_frame;

    // ----------------------------------------------------------------
    // registers and mode
    // ----------------------------------------------------------------
    lpp_gnd_t slow_gnd, next_slow_gnd, deb_gnd, next_deb_gnd;
    lpp_prg_t deb_prg, next_deb_prg;
    lpp_mode_t mode, next_mode;
    logic int_flag, next_int_flag;
    logic wr_frame, rd_frame, sleep_cmd, status_read, wake_set;
    lpp_data_t rd_data;

    assign wr_frame = frame_done && rx_shift[`LPP_RW_BIT];
    assign rd_frame = frame_done && !rx_shift[`LPP_RW_BIT];
    // only the all-zero write is taken as the sleep command
    assign sleep_cmd = wr_frame && addr_is(rx_shift, `LPP_ADDR_SLEEP) &&
        rx_shift[23:0] == 24'h0;
    assign status_read = rd_frame && addr_is(rx_shift, `LPP_ADDR_SW_STATUS);

    always_comb
    begin
        next_slow_gnd = slow_gnd;
        next_deb_prg = deb_prg;
        next_deb_gnd = deb_gnd;
        next_mode = mode;
        wake_set = 1'b0;
        if (wr_frame && addr_is(rx_shift, `LPP_ADDR_SLOW_GND))
            next_slow_gnd = rx_shift[`LPP_GND_CH-1:0];
        if (wr_frame && addr_is(rx_shift, `LPP_ADDR_DEB_PRG))
            next_deb_prg = rx_shift[`LPP_PRG_CH-1:0];
        if (wr_frame && addr_is(rx_shift, `LPP_ADDR_DEB_GND))
            next_deb_gnd = rx_shift[`LPP_GND_CH-1:0];
        case (mode)
            st_normal:
                if (sleep_cmd)
                    next_mode = st_sleep;
            st_sleep:
                if (wake_i)
                begin
                    // settings are left untouched on the way out
                    next_mode = st_normal;
                    wake_set = 1'b1;
                end
            default:
                next_mode = st_normal;
        endcase
        // set wins over the clear in the same cycle
        next_wake_pending = (wake_pending && !frame_done) || wake_set;
        next_int_flag = (int_flag && !status_read) || int_event_i || wake_set;
        case (rx_shift[`LPP_ADDR_MSB:`LPP_ADDR_LSB])
            `LPP_ADDR_SLOW_GND: rd_data = 22'(slow_gnd);
            `LPP_ADDR_DEB_PRG: rd_data = 22'(deb_prg);
            `LPP_ADDR_DEB_GND: rd_data = 22'(deb_gnd);
            `LPP_ADDR_SW_STATUS: rd_data = {programmable_switch_input_state_i,
                ground_switch_input_state_i};
            default: rd_data = 22'h0;
        endcase
        next_reply_q = reply_q;
        if (frame_done)
            next_reply_q = {rx_shift[31:24], fault_pending_i, int_flag, rd_data};
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rx_shift <= '0;
            tx_shift <= '0;
            bit_cnt <= 6'h0;
            in_frame <= 1'b0;
            reply_q <= `LPP_RST_REPLY;
            slow_gnd <= `LPP_RST_SLOW_GND;
            deb_prg <= `LPP_RST_DEB_PRG;
            deb_gnd <= `LPP_RST_DEB_GND;
            mode <= st_normal;
            int_flag <= 1'b1;
            wake_pending <= 1'b0;
        end
        else if (clk_en_i)
        begin
            rx_shift <= next_rx_shift;
            tx_shift <= next_tx_shift;
            bit_cnt <= next_bit_cnt;
            in_frame <= next_in_frame;
            reply_q <= next_reply_q;
            slow_gnd <= next_slow_gnd;
            deb_prg <= next_deb_prg;
            deb_gnd <= next_deb_gnd;
            mode <= next_mode;
            int_flag <= next_int_flag;
            wake_pending <= next_wake_pending;
        end
    end

    assign sleep_mode_o = (mode == st_sleep);

    // ----------------------------------------------------------------
    // polling scheduler
    // ----------------------------------------------------------------
    lpp_poll_sched #(
        .BASE_CYC(POLL_BASE_CYC),
        .EXT_CYC(DEB_EXT_CYC)
    ) u_sched (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .sleep_mode_i(sleep_mode_o),
        .poll_tick_i(poll_tick_i),
        .slow_gnd_i(slow_gnd),
        .deb_gnd_i(deb_gnd),
        .deb_prg_i(deb_prg),
        .gnd_current_o(ground_switch_input_current_o),
        .prg_current_o(programmable_switch_input_current_o),
        .gnd_measure_o(ground_switch_input_measure_o),
        .prg_measure_o(programmable_switch_input_measure_o)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i iff clk_en_i);
    endclocking
    default disable iff (!rst_b_i);

    a_sleep_entry: assert property (sleep_cmd && mode == st_normal |=> sleep_mode_o)
        else $error("sleep command not taken");
    a_sleep_cause: assert property ($rose(sleep_mode_o) |-> $past(sleep_cmd))
        else $error("sleep entered without the command");
    a_slow_write: assert property (wr_frame && addr_is(rx_shift, `LPP_ADDR_SLOW_GND)
        |=> slow_gnd == $past(rx_shift[13:0]))
        else $error("ground slow-poll write lost");
    a_deb_prg_write: assert property (wr_frame && addr_is(rx_shift, `LPP_ADDR_DEB_PRG)
        |=> deb_prg == $past(rx_shift[7:0]))
        else $error("programmable debounce write lost");
    a_deb_gnd_write: assert property (wr_frame && addr_is(rx_shift, `LPP_ADDR_DEB_GND)
        |=> deb_gnd == $past(rx_shift[13:0]))
        else $error("ground debounce write lost");
    a_keep_on_wake: assert property (wake_set && !frame_done
        |=> $stable(slow_gnd) && $stable(deb_gnd) && $stable(deb_prg))
        else $error("settings changed on wake");
    a_wake_reply: assert property (cs_fall && wake_pending
        |=> tx_shift[23:22] == `LPP_FLAGS_WAKE && tx_shift[21:0] ==
        {$past(programmable_switch_input_state_i), $past(ground_switch_input_state_i)})
        else $error("first frame after wake lacks flags or inputs");
    a_flag_reply: assert property (frame_done |=> reply_q[23] == $past(fault_pending_i)
        && reply_q[22] == $past(int_flag))
        else $error("reply flags wrong");
    a_int_clear: assert property (status_read && !int_event_i && !wake_set |=> !int_flag)
        else $error("status read left interrupt flag set");
    a_echo_addr: assert property (frame_done |=> reply_q[31:25] == $past(rx_shift[31:25]))
        else $error("reply address field wrong");
    a_cfg_read: assert property (rd_frame && addr_is(rx_shift, `LPP_ADDR_DEB_GND)
        |=> reply_q[21:0] == 22'($past(deb_gnd)))
        else $error("config read data wrong");

    c_sleep_enter: cover property (sleep_cmd ##1 sleep_mode_o);
    c_wake_frame: cover property (wake_set ##[1:1000] (cs_fall && wake_pending));
    c_status_read: cover property (status_read && int_flag);
endmodule

//--- testbench/lpp_host.sv
// spi host model that issues 32-bit command frames or cut frames of fewer bits, mode 0, msb first
module lpp_host (
    // clock
    input wire logic clk_i,
    // serial pins
    output logic sclk_o,
    output logic cs_b_o,
    output logic mosi_o,
    input wire logic miso_i,
    // frame status
    output logic done_o,
    output logic [31:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        mosi_o = 1'b0;
        done_o = 1'b0;
        rx_o = 32'h0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // six system clocks per half bit keeps sclk well under a tenth of clk
    task automatic xfer_n(input logic [31:0] tx, input int nb);
        logic [31:0] rx;
        gap(1);
        cs_b_o = 1'b0;
        gap(6);
        for (int i = 31; i >= 32 - nb; i--)
        begin
            mosi_o = tx[i];
            gap(6);
            rx[i] = miso_i;
            sclk_o = 1'b1;
            gap(6);
            sclk_o = 1'b0;
        end
        gap(6);
        cs_b_o = 1'b1;
        // released data line shows the inverse so a stale bit cannot pass
        mosi_o = ~tx[32 - nb];
        rx_o = rx;
        // a cut frame has no reply for the bench to check
        done_o = (nb == 32);
        gap(1);
        done_o = 1'b0;
        gap(8);
    endtask
    task automatic xfer(input logic [31:0] tx);
        xfer_n(tx, 32);
    endtask
    task automatic sleep_cmd();
        xfer({7'h1c, 1'b1, 24'h000000});
    endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the sleep-mode polling configuration bank
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lpp_pkg::*;
    localparam int BASE = 8;
    localparam int EXT = 40;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sclk, cs_b, mosi, miso, miso_oe, miso_w, done, sleep_mode;
    logic [31:0] rx, e, m, exp_next, cur_msk;
    logic fault = 1'b0;
    logic intev = 1'b0;
    logic wake = 1'b0;
    logic clk_en = 1'b1;
    logic tick = 1'b0;
    lpp_gnd_t gnd_in = 14'h0;
    lpp_prg_t prg_in = 8'h0;
    lpp_gnd_t gnd_cur, gnd_meas;
    lpp_prg_t prg_cur, prg_meas;
    logic [31:0] q_exp[$];
    logic [31:0] q_msk[$];
    logic [6:0] adr[3] = '{7'h19, 7'h1a, 7'h1b};
    logic [21:0] wm[3] = '{22'h3fff, 22'hff, 22'h3fff};
    logic [21:0] cfg[3];
    logic fault_x, int_f;
    int n_errors = 0;
    int comparisons = 0;
    int mg[14], cg[14], mp[8], cp[8];
    int seed_v;
    always #12.5 clk_sys_i = ~clk_sys_i;
    assign miso_w = miso_oe ? miso : ~miso;
    lpp_sleep_cfg #(.POLL_BASE_CYC(BASE), .DEB_EXT_CYC(EXT)) i_lpp_sleep_cfg (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
        .spi_sclk_i(sclk), .spi_cs_b_i(cs_b), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .ground_switch_input_state_i(gnd_in), .programmable_switch_input_state_i(prg_in),
        .fault_pending_i(fault), .int_event_i(intev), .wake_i(wake), .poll_tick_i(tick),
        .sleep_mode_o(sleep_mode), .ground_switch_input_current_o(gnd_cur),
        .programmable_switch_input_current_o(prg_cur),
        .ground_switch_input_measure_o(gnd_meas),
        .programmable_switch_input_measure_o(prg_meas));
    lpp_host i_lpp_host (.clk_i(clk_sys_i), .sclk_o(sclk), .cs_b_o(cs_b), .mosi_o(mosi),
        .miso_i(miso_w), .done_o(done), .rx_o(rx));
    // --------------------------------
    // reply monitor and poll counters
    // --------------------------------
    always @(posedge clk_sys_i)
    begin
        if (done === 1'b1)
        begin
            e = q_exp.pop_front();
            m = q_msk.pop_front();
            `CHK(rx & m, e & m)
        end
        for (int c = 0; c < 14; c++)
        begin
            mg[c] += (gnd_meas[c] === 1'b1);
            cg[c] += (gnd_cur[c] === 1'b1);
        end
        for (int c = 0; c < 8; c++)
        begin
            mp[c] += (prg_meas[c] === 1'b1);
            cp[c] += (prg_cur[c] === 1'b1);
        end
    end
    task automatic report_and_stop();
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // each frame's reply is the previous frame's echo, flags and data
    task automatic op(input logic [6:0] a, input logic w, input logic [23:0] d,
                      input logic [21:0] rd);
        q_exp.push_back(exp_next);
        q_msk.push_back(cur_msk);
        i_lpp_host.xfer({a, w, d});
        exp_next = {a, w, fault_x, int_f, rd};
        cur_msk = 32'hffffffff;
        if (a == 7'h1f)
            int_f = 1'b0;
    endtask
    // flags are captured at frame end, so a change between frames shows next time
    task automatic set_flags(input logic f, input logic i);
        fault = f;
        fault_x = f;
        intev = i;
        int_f = int_f | i;
        @(negedge clk_sys_i);
        intev = 1'b0;
    endtask
    task automatic wait_mode(input logic v);
        for (int k = 0; k < 20 && sleep_mode !== v; k++)
            @(negedge clk_sys_i);
        comparisons++;
        if (sleep_mode !== v)
        begin
            n_errors++;
            $display("[ERR] %0t sleep mode did not reach %b", $time, v);
            report_and_stop();
        end
    endtask
    initial
    begin
        repeat (100000) @(posedge clk_sys_i);
        n_errors++;
        $display("[ERR] %0t run timed out", $time);
        report_and_stop();
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial
    begin
        seed_v = $urandom(32'h2d4b);
        repeat (8) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        exp_next = 32'h00c00000;
        cur_msk = 32'hffffffff;
        int_f = 1'b1;
        fault_x = 1'b0;
        foreach (adr[i]) op(adr[i], 1'b0, 24'h0, 22'h0);
        foreach (adr[i])
        begin
            // a write reply carries the value held before the write
            op(adr[i], 1'b1, 24'hffffff, 22'h0);
            op(adr[i], 1'b0, 24'h0, wm[i]);
        end
        foreach (adr[i])
        begin
            cfg[i] = $urandom & wm[i];
            op(adr[i], 1'b1, {$urandom} & 24'hffc000 | cfg[i], wm[i]);
        end
        // a 31-bit write must be dropped; the later reads of this register prove it
        i_lpp_host.xfer_n({adr[0], 1'b1, 10'h0, ~cfg[0][13:0]}, 31);
        op(7'h1c, 1'b0, 24'h0, 22'h0);
        op(7'h05, 1'b1, 24'h0000aa, 22'h0);
        op(7'h1c, 1'b1, 24'h000001, 22'h0);
        repeat (10) @(negedge clk_sys_i);
        `CHK(sleep_mode, 1'b0)
        gnd_in = $urandom;
        prg_in = $urandom;
        op(7'h1f, 1'b0, 24'h0, {prg_in, gnd_in});
        op(adr[0], 1'b0, 24'h0, cfg[0]);
        set_flags(1'b1, 1'b1);
        op(adr[1], 1'b0, 24'h0, cfg[1]);
        op(adr[2], 1'b0, 24'h0, cfg[2]);
        set_flags(1'b0, 1'b0);
        op(7'h1f, 1'b0, 24'h0, {prg_in, gnd_in});
        q_exp.push_back(exp_next);
        q_msk.push_back(cur_msk);
        i_lpp_host.sleep_cmd();
        wait_mode(1'b1);
        // a wake request while the enable is low must not be seen
        clk_en = 1'b0;
        wake = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        wake = 1'b0;
        clk_en = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        `CHK(sleep_mode, 1'b1)
        foreach (mg[c]) mg[c] = 0;
        foreach (cg[c]) cg[c] = 0;
        foreach (mp[c]) mp[c] = 0;
        foreach (cp[c]) cp[c] = 0;
        repeat (4)
        begin
            tick = 1'b1;
            @(negedge clk_sys_i);
            tick = 1'b0;
            repeat (1200) @(negedge clk_sys_i);
        end
        for (int c = 0; c < 14; c++)
        begin
            `CHK(mg[c], cfg[0][c] ? 1 : 4)
            `CHK(cg[c], (cfg[0][c] ? 1 : 4) * (BASE + (cfg[2][c] ? EXT : 0)))
        end
        for (int c = 0; c < 8; c++)
        begin
            `CHK(mp[c], 4)
            `CHK(cp[c], 4 * (BASE + (cfg[1][c] ? EXT : 0)))
        end
        gnd_in = $urandom;
        prg_in = $urandom;
        wake = 1'b1;
        @(negedge clk_sys_i);
        wake = 1'b0;
        wait_mode(1'b0);
        repeat (10) @(negedge clk_sys_i);
        int_f = 1'b1;
        exp_next = {8'h00, 1'b1, 1'b1, prg_in, gnd_in};
        cur_msk = 32'hffffffff;
        foreach (adr[i]) op(adr[i], 1'b0, 24'h0, cfg[i]);
        op(7'h1f, 1'b0, 24'h0, {prg_in, gnd_in});
        op(adr[0], 1'b0, 24'h0, cfg[0]);
        report_and_stop();
    end
endmodule
